//--- ipd_divider_chain.sv
// dual-modulus divider chain with parallel double-buffered programming
//
// Behaviour
// - prescaler divides rf input by ten or eleven per modulus select
// - reference and main counters take values from one 20-bit register
// - swallow counter drives modulus select, setting how many cycles use eleven
// - main chain is prescaler, modulus select logic and 9-bit main counter
// - bypass low runs prescaler; high skips it and powers it down
// - main output is rf over ten times main plus one, plus swallow
// - main value one gives a main division of two
// - direct mode forces main bits eight and seven to zero
// - 6-bit reference counter divides reference by value plus one
// - reference value zero passes reference input undivided
// - direct mode forces reference bits five and four to zero
// - strobe rising edge in parallel mode captures data byte (main-high: low nibble only) into its primary section
// - hop strobe rising edge outside direct mode copies whole primary into secondary
// - phase detector gives separate up and down pulses
// - main-low strobe loads bypass bit and main bits six to zero
// - main-high strobe loads reference five, four and main eight, seven
// - swallow-reference strobe loads reference three to zero and swallow
// - in parallel mode, bank select high uses primary, low uses secondary
`timescale 1ns/10ps
module ipd_divider_chain
  import ipd_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  input  wire logic              rf_in,
  input  wire logic              ref_in,
  input  wire logic [BYTE_W-1:0] data_in,
  input  wire logic              main_low_byte_strobe,
  input  wire logic              main_high_nibble_strobe,
  input  wire logic              swallow_ref_strobe,
  input  wire logic              hop_strobe,
  input  wire logic              parallel_bank_select,
  input  wire logic              direct_mode_sel,
  input  wire logic              serial_mode_sel,
  input  wire logic              direct_bypass,
  input  wire logic [6:0]        direct_main,
  input  wire logic [3:0]        direct_ref,
  input  wire logic [SWL_W-1:0]  direct_swallow,
  output logic                   main_div_out,
  output logic                   ref_div_out,
  output logic                   modulus_select,
  output logic                   prescaler_pd,
  output logic                   pd_up,
  output logic                   pd_down
);

  // ************************************************************
  // mode decode and strobe edges
  // ************************************************************
  ipd_mode_t mode;
  always_comb begin
    if (direct_mode_sel) begin
      mode = IPD_MODE_DIRECT;
    end else if (serial_mode_sel) begin
      mode = IPD_MODE_SERIAL;
    end else begin
      mode = IPD_MODE_PARALLEL;
    end
  end

  logic [3:0]        strobe_prev;
  logic [3:0]        next_strobe_prev;
  logic [PROG_W-1:0] primary;
  logic [PROG_W-1:0] next_primary;
  logic [PROG_W-1:0] secondary;
  logic [PROG_W-1:0] next_secondary;
  logic              low_rise;
  logic              high_rise;
  logic              swr_rise;
  logic              hop_rise;
  logic              par_mode;

  assign par_mode  = (mode == IPD_MODE_PARALLEL);
  assign low_rise  = main_low_byte_strobe & ~strobe_prev[0];
  assign high_rise = main_high_nibble_strobe & ~strobe_prev[1];
  assign swr_rise  = swallow_ref_strobe & ~strobe_prev[2];
  assign hop_rise  = hop_strobe & ~strobe_prev[3];

  // ************************************************************
  // primary and secondary registers
  // ************************************************************
  always_comb begin
    next_strobe_prev = {hop_strobe, swallow_ref_strobe,
                        main_high_nibble_strobe, main_low_byte_strobe};
    next_primary     = primary;
    next_secondary   = secondary;
    if (par_mode && low_rise) begin
      next_primary[POS_BYPASS:POS_MAIN_LO] = data_in;
    end
    if (par_mode && high_rise) begin
      next_primary[POS_REF_HI+1:POS_MAIN_HI] = data_in[3:0];
    end
    if (par_mode && swr_rise) begin
      next_primary[POS_REF_LO+3:POS_SWL] = data_in;
    end
    if (mode != IPD_MODE_DIRECT && hop_rise) begin
      next_secondary = primary;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      strobe_prev <= 4'h0;
      primary     <= PROG_RESET;
      secondary   <= PROG_RESET;
    end else begin
      strobe_prev <= next_strobe_prev;
      primary     <= next_primary;
      secondary   <= next_secondary;
    end
  end

  // ************************************************************
  // active programming word
  // ************************************************************
  logic [PROG_W-1:0] active;
  always_comb begin
    case (mode)
      IPD_MODE_DIRECT: begin
        active = {4'h0, direct_bypass, direct_main, direct_ref, direct_swallow};
      end
      IPD_MODE_PARALLEL: begin
        active = parallel_bank_select ? primary : secondary;
      end
      default: begin
        active = secondary;
      end
    endcase
  end

  // ************************************************************
  // divider chain
  // ************************************************************
  logic [PROG_W-1:0] cfg;
  logic [PROG_W-1:0] next_cfg;
  logic              rf_prev;
  logic              ref_prev;
  logic [PSC_W-1:0]  psc_cnt;
  logic [PSC_W-1:0]  next_psc_cnt;
  logic [SWL_W-1:0]  swl;
  logic [SWL_W-1:0]  next_swl;
  logic [MAIN_W-1:0] mcnt;
  logic [MAIN_W-1:0] next_mcnt;
  logic [REF_W-1:0]  rcnt;
  logic [REF_W-1:0]  next_rcnt;
  logic              next_main_div_out;
  logic              next_ref_div_out;
  logic              rf_rise;
  logic              ref_rise;
  logic              bypass;
  logic              pre_pulse;
  logic [PSC_W-1:0]  psc_last;
  logic [REF_W-1:0]  cfg_ref;

  assign rf_rise  = rf_in & ~rf_prev;
  assign ref_rise = ref_in & ~ref_prev;
  assign bypass   = cfg[POS_BYPASS];
  assign cfg_ref  = {cfg[POS_REF_HI+1:POS_REF_HI], cfg[POS_REF_LO+3:POS_REF_LO]};
  assign modulus_select = (swl != 4'h0) && !bypass;
  assign prescaler_pd   = bypass;
  assign psc_last = modulus_select ? PSC_HIGH_LAST : PSC_LOW_LAST;
  assign pre_pulse = bypass ? rf_rise : (rf_rise && psc_cnt == psc_last);

  always_comb begin
    next_cfg          = cfg;
    next_psc_cnt      = psc_cnt;
    next_swl          = swl;
    next_mcnt         = mcnt;
    next_rcnt         = rcnt;
    next_main_div_out = 1'b0;
    next_ref_div_out  = 1'b0;
    if (bypass) begin
      next_psc_cnt = 4'h0;
    end else if (rf_rise) begin
      next_psc_cnt = (psc_cnt == psc_last) ? 4'h0 : psc_cnt + 4'h1;
    end
    if (pre_pulse) begin
      if (mcnt == 9'h000) begin
        next_cfg          = active;
        next_mcnt         = {active[POS_MAIN_HI+1:POS_MAIN_HI],
                             active[POS_MAIN_LO+6:POS_MAIN_LO]};
        next_swl          = active[POS_SWL+3:POS_SWL];
        next_main_div_out = 1'b1;
      end else begin
        next_mcnt = mcnt - 9'h001;
        next_swl  = (swl != 4'h0) ? swl - 4'h1 : 4'h0;
      end
    end
    if (ref_rise) begin
      if (rcnt == 6'h00) begin
        next_rcnt        = cfg_ref;
        next_ref_div_out = 1'b1;
      end else begin
        next_rcnt = rcnt - 6'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg          <= PROG_RESET;
      rf_prev      <= 1'b0;
      ref_prev     <= 1'b0;
      psc_cnt      <= 4'h0;
      swl          <= 4'h0;
      mcnt         <= 9'h000;
      rcnt         <= 6'h00;
      main_div_out <= 1'b0;
      ref_div_out  <= 1'b0;
    end else begin
      cfg          <= next_cfg;
      rf_prev      <= rf_in;
      ref_prev     <= ref_in;
      psc_cnt      <= next_psc_cnt;
      swl          <= next_swl;
      mcnt         <= next_mcnt;
      rcnt         <= next_rcnt;
      main_div_out <= next_main_div_out;
      ref_div_out  <= next_ref_div_out;
    end
  end

  // ************************************************************
  // phase-frequency detector
  // ************************************************************
  logic next_pd_up;
  logic next_pd_down;
  always_comb begin
    next_pd_up   = pd_up | ref_div_out;
    next_pd_down = pd_down | main_div_out;
    if (next_pd_up && next_pd_down) begin
      next_pd_up   = 1'b0;
      next_pd_down = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pd_up   <= 1'b0;
      pd_down <= 1'b0;
    end else begin
      pd_up   <= next_pd_up;
      pd_down <= next_pd_down;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_low_byte_load: assert property (
    par_mode && low_rise |=> primary[15:8] == $past(data_in))
    else $error("main low byte not captured");
  a_high_nib_load: assert property (
    par_mode && high_rise |=> primary[19:16] == $past(data_in[3:0]))
    else $error("main high nibble not captured");
  a_swref_load: assert property (
    par_mode && swr_rise |=> primary[7:0] == $past(data_in))
    else $error("swallow reference byte not captured");
  a_hop_copy: assert property (
    !direct_mode_sel && hop_rise |=> secondary == $past(primary))
    else $error("hop copy missing");
  a_direct_force: assert property (
    direct_mode_sel |-> active[19:16] == 4'h0)
    else $error("direct mode high bits not forced low");
  a_psc_range: assert property (
    !bypass && psc_cnt == 4'hA |-> $past(modulus_select))
    else $error("prescaler counted to eleven without modulus select");
  a_bypass_hold: assert property (
    bypass |-> psc_cnt == 4'h0 && !modulus_select)
    else $error("prescaler active while bypassed");
  a_main_pulse: assert property (
    pre_pulse && mcnt == 9'h000 |=> main_div_out && swl == $past(active[3:0]))
    else $error("main reload missing");
  a_ref_pass: assert property (
    ref_rise && rcnt == 6'h00 && cfg_ref == 6'h00 |=> ref_div_out ##1 rcnt == 6'h00)
    else $error("zero reference not passed through");
  a_pfd_excl: assert property (
    !(pd_up && pd_down))
    else $error("up and down together");
  a_main_count: assert property (
    pre_pulse && mcnt != 9'h000 |=> mcnt == $past(mcnt) - 9'h001 && !main_div_out)
    else $error("main counter did not step down");
  a_bank_pick: assert property (
    par_mode && pre_pulse && mcnt == 9'h000 |=>
    cfg == ($past(parallel_bank_select) ? $past(primary) : $past(secondary)))
    else $error("counters loaded from the wrong register");
  a_primary_hold: assert property (
    !par_mode |=> primary == $past(primary))
    else $error("primary written outside parallel mode");

  c_main_out: cover property (main_div_out);
  c_ref_out:  cover property (ref_div_out ##1 pd_up);
  c_hop:      cover property (par_mode && hop_rise);
  c_eleven:   cover property (modulus_select && pre_pulse);
  c_bypass:   cover property (prescaler_pd && main_div_out);

endmodule : ipd_divider_chain

//--- ipd_pkg.sv
// constants for the integer divider chain and its programming path
package ipd_pkg;

  // ************************************************************
  // programming word layout
  // ************************************************************
  localparam int unsigned PROG_W  = 20;
  localparam int unsigned MAIN_W  = 9;
  localparam int unsigned REF_W   = 6;
  localparam int unsigned SWL_W   = 4;
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned PSC_W   = 4;

  localparam int unsigned POS_REF_HI  = 18;
  localparam int unsigned POS_MAIN_HI = 16;
  localparam int unsigned POS_BYPASS  = 15;
  localparam int unsigned POS_MAIN_LO = 8;
  localparam int unsigned POS_REF_LO  = 4;
  localparam int unsigned POS_SWL     = 0;

  localparam logic [PROG_W-1:0] PROG_RESET = 20'h00000;

  // ************************************************************
  // prescaler ratios
  // ************************************************************
  localparam logic [PSC_W-1:0] PSC_LOW_LAST  = 4'h9;
  localparam logic [PSC_W-1:0] PSC_HIGH_LAST = 4'hA;

  // ************************************************************
  // interface modes
  // ************************************************************
  typedef enum logic [1:0] {
    IPD_MODE_PARALLEL,
    IPD_MODE_SERIAL,
    IPD_MODE_DIRECT
  } ipd_mode_t;

endpackage : ipd_pkg

//--- ipd_host_model.sv
// host model driving the parallel programming pins
`timescale 1ns/10ps
module ipd_host_model (
  input  wire logic  sys_clk,
  output logic [7:0] data_in,
  output logic [3:0] wr,
  output logic       direct_mode_sel,
  output logic       serial_mode_sel,
  output logic       parallel_bank_select
);
  initial begin
    data_in = 8'h00;
    wr = 4'h0;
    direct_mode_sel = 1'b0;
    serial_mode_sel = 1'b0;
    parallel_bank_select = 1'b0;
  end
  // one rise per call, data held over the capturing edge
  task automatic put(input int idx, input logic [7:0] b);
    @(posedge sys_clk);
    data_in <= b;
    wr[idx] <= 1'b1;
    @(posedge sys_clk);
    wr <= 4'h0;
    data_in <= 8'h00; // pull-down once released
  endtask : put
  task automatic load(input logic [19:0] w, input logic hop);
    put(0, w[15:8]);
    put(1, {4'h0, w[19:16]});
    put(2, w[7:0]);
    if (hop) begin
      put(3, 8'h00);
    end
  endtask : load
  task automatic set_mode(input logic d, input logic s, input logic bank);
    @(posedge sys_clk);
    direct_mode_sel <= d;
    serial_mode_sel <= s;
    parallel_bank_select <= bank;
  endtask : set_mode
endmodule : ipd_host_model

//--- test_ipd_divider_chain.sv
// self-checking bench for the divider chain
`timescale 1ns/10ps
module test_ipd_divider_chain;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        rf_in = 1'b0;
  logic        ref_in = 1'b0;
  logic [7:0]  data_in;
  logic [3:0]  wr;
  logic        dsel, ssel, bank;
  logic        direct_bypass = 1'b0;
  logic [6:0]  direct_main = 7'h00;
  logic [3:0]  direct_ref = 4'h0;
  logic [3:0]  direct_swallow = 4'h0;
  logic        main_div_out, ref_div_out, modulus_select, prescaler_pd, pd_up, pd_down;
  int          failures = 0;
  int          comparisons = 0;
  int          seed = 32'hA158;
  logic [1:0]  pfd_exp = 2'h0;
  logic [19:0] corner [4] = '{20'h00100, 20'h08100, 20'hE00F5, 20'h00304};

  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) rf_in <= ~rf_in;
  always @(posedge sys_clk) ref_in <= ~ref_in;

  ipd_host_model host_u (.sys_clk(sys_clk), .data_in(data_in), .wr(wr), .direct_mode_sel(dsel),
                         .serial_mode_sel(ssel), .parallel_bank_select(bank));

  ipd_divider_chain dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .rf_in(rf_in), .ref_in(ref_in),
    .data_in(data_in), .main_low_byte_strobe(wr[0]), .main_high_nibble_strobe(wr[1]),
    .swallow_ref_strobe(wr[2]), .hop_strobe(wr[3]), .parallel_bank_select(bank),
    .direct_mode_sel(dsel), .serial_mode_sel(ssel), .direct_bypass(direct_bypass),
    .direct_main(direct_main), .direct_ref(direct_ref), .direct_swallow(direct_swallow),
    .main_div_out(main_div_out), .ref_div_out(ref_div_out), .modulus_select(modulus_select),
    .prescaler_pd(prescaler_pd), .pd_up(pd_up), .pd_down(pd_down));

  // ************************************************************
  // checking helpers
  // ************************************************************
  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  function automatic logic [31:0] main_cycles(input logic [19:0] w);
    logic [8:0] m;
    m = {w[17:16], w[14:8]};
    return w[15] ? 2 * (m + 1) : 2 * (10 * (m + 1) + w[3:0]);
  endfunction : main_cycles

  function automatic logic [31:0] ref_cycles(input logic [19:0] w);
    return 2 * ({w[19:18], w[7:4]} + 1);
  endfunction : ref_cycles

  // two clocks per rf edge, eleven rf edges per swallowed prescaler cycle
  function automatic logic [31:0] swallow_cycles(input logic [19:0] w);
    return w[15] ? 0 : 22 * w[3:0];
  endfunction : swallow_cycles

  // up follows a reference pulse, down a main pulse, both together clear
  function automatic logic [1:0] pfd_next(input logic [3:0] s);
    logic u;
    logic d;
    u = s[3] | s[1];
    d = s[2] | s[0];
    return (u & d) ? 2'h0 : {u, d};
  endfunction : pfd_next

  // cycles up to the next pulse of one divider output, and cycles with modulus select high
  task automatic period(input logic sel, output logic [31:0] n, output logic [31:0] k);
    n = 0;
    k = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (modulus_select === 1'b1) begin
        k++;
      end
      if (n > 20000) begin
        failures++;
        conclude();
      end
    end while ((sel ? ref_div_out : main_div_out) !== 1'b1);
  endtask : period

  // skip pulses until the new word is latched, then measure
  task automatic expect_periods(input logic [19:0] w);
    logic [31:0] n;
    logic [31:0] k;
    repeat (3) period(1'b0, n, k);
    check(n, main_cycles(w));
    check(k, swallow_cycles(w));
    repeat (3) period(1'b1, n, k);
    check(n, ref_cycles(w));
  endtask : expect_periods

  task automatic run_word(input logic [19:0] w);
    host_u.load(w, 1'b1);
    expect_periods(w);
    check(prescaler_pd, w[15]);
  endtask : run_word

  // phase detector against a model of the up/down rule
  always @(posedge sys_clk) begin
    if (arst_n) begin
      check(pd_up & pd_down, 0);
      check({pd_up, pd_down}, pfd_exp);
    end
    pfd_exp <= pfd_next({pd_up, pd_down, ref_div_out, main_div_out});
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin : main_seq
    logic [19:0] w;
    repeat (10) @(posedge sys_clk);
    check({main_div_out, ref_div_out, pd_up, pd_down, prescaler_pd}, 0);
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    foreach (corner[i]) begin
      run_word(corner[i]);
    end
    repeat (4) begin
      w = 20'($random(seed));
      w[17:16] = 2'h0;
      w[14:8] = 7'(15 + {$random(seed)} % 20);
      run_word(w);
    end
    host_u.load(20'h00500, 1'b1);
    host_u.load(20'h00702, 1'b0);
    host_u.set_mode(1'b0, 1'b0, 1'b1);
    expect_periods(20'h00702);
    host_u.set_mode(1'b0, 1'b0, 1'b0);
    expect_periods(20'h00500);
    host_u.set_mode(1'b0, 1'b1, 1'b1);
    host_u.load(20'h00900, 1'b0);
    host_u.set_mode(1'b0, 1'b0, 1'b1);
    expect_periods(20'h00702);
    host_u.load(20'hF0000, 1'b1);
    direct_main <= 7'h04;
    direct_ref <= 4'h2;
    direct_swallow <= 4'h3;
    host_u.set_mode(1'b1, 1'b0, 1'b1);
    expect_periods(20'h00423);
    direct_bypass <= 1'b1;
    expect_periods(20'h08423);
    check(prescaler_pd, 1'b1);
    conclude();
  end
endmodule : test_ipd_divider_chain
